// File: logic/flow_pkg.sv
// shared constants, command codes and carriers for the program-flow unit
package flow_pkg;

    // register byte offsets
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] instr_off = 8'h04;
    localparam logic [7:0] opnd_off = 8'h08;
    localparam logic [7:0] pc_off = 8'h0c;
    localparam logic [7:0] flags_off = 8'h10;
    localparam logic [7:0] stack_off = 8'h14;
    localparam logic [7:0] state_off = 8'h18;
    localparam logic [7:0] retired_off = 8'h1c;

    // instruction register fields
    localparam int op_pos = 0;
    localparam int bit_pos = 8;
    localparam int sel_pos = 12;
    localparam int k_pos = 16;
    localparam int two_word_pos = 24;

    // operand register fields
    localparam int opnd_a_pos = 0;
    localparam int opnd_b_pos = 8;
    localparam int io_pos = 16;

    // state register fields
    localparam int busy_pos = 0;
    localparam int taken_pos = 1;
    localparam int bad_op_pos = 2;
    localparam int cycles_pos = 4;

    // status flag positions
    localparam int flag_c = 0;
    localparam int flag_z = 1;
    localparam int flag_n = 2;
    localparam int flag_v = 3;
    localparam int flag_s = 4;
    localparam int flag_h = 5;
    localparam int flag_t = 6;
    localparam int flag_i = 7;

    // reset values
    localparam logic [15:0] pc_rst = 16'h0000;
    localparam logic [7:0] flags_rst = 8'h00;
    localparam logic [15:0] stack_rst = 16'h0000;

    // cycle counts
    localparam logic [2:0] cyc_plain = 3'h1;
    localparam logic [2:0] cyc_taken = 3'h2;
    localparam logic [2:0] cyc_skip_long = 3'h3;
    localparam logic [2:0] cyc_return = 3'h4;

    typedef enum logic [4:0] {
        op_nop = 5'h00,
        subroutine_return = 5'h01,
        interrupt_return = 5'h02,
        compare_skip_equal = 5'h03,
        compare_regs = 5'h04,
        compare_regs_with_carry = 5'h05,
        compare_immediate = 5'h06,
        skip_reg_bit_clear = 5'h07,
        skip_reg_bit_set = 5'h08,
        skip_io_bit_clear = 5'h09,
        skip_io_bit_set = 5'h0a,
        branch_flag_set = 5'h0b,
        branch_flag_clear = 5'h0c,
        branch_equal = 5'h0d,
        branch_not_equal = 5'h0e,
        branch_carry_set = 5'h0f,
        branch_carry_clear = 5'h10,
        branch_same_or_higher = 5'h11,
        branch_lower = 5'h12,
        branch_minus = 5'h13,
        branch_plus = 5'h14,
        branch_signed_ge = 5'h15,
        branch_signed_lt = 5'h16,
        branch_half_carry_set = 5'h17,
        branch_half_carry_clear = 5'h18,
        branch_transfer_bit_set = 5'h19,
        branch_transfer_bit_clear = 5'h1a
    } op_e;

    typedef struct packed {
        logic two_word;
        logic [6:0] k;
        logic [2:0] flag_sel;
        logic [2:0] bit_sel;
        op_e op;
    } instr_s;

    typedef struct packed {
        logic [7:0] io_val;
        logic [7:0] opnd_b;
        logic [7:0] opnd_a;
    } operands_s;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] flags;
        logic [2:0] cycles;
        logic taken;
        logic bad_op;
    } outcome_s;

endpackage : flow_pkg

// File: logic/compare_flags.sv
// subtract-and-discard compare producing the updated status flags
`timescale 1ns/100ps
module compare_flags (
    // operands
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic with_carry,
    // flags
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out
);
    logic [8:0] diff;
    logic [7:0] res;
    logic borrow_in;

    always_comb begin
        borrow_in = with_carry & flags_in[flow_pkg::flag_c];
        diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
        res = diff[7:0];
        flags_out = flags_in;
        flags_out[flow_pkg::flag_c] = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & res[7])
            | (res[7] & ~minuend[7]);
        flags_out[flow_pkg::flag_h] = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & res[3])
            | (res[3] & ~minuend[3]);
        flags_out[flow_pkg::flag_v] = (minuend[7] & ~subtrahend[7] & ~res[7])
            | (~minuend[7] & subtrahend[7] & res[7]);
        flags_out[flow_pkg::flag_n] = res[7];
        flags_out[flow_pkg::flag_s] = res[7] ^ flags_out[flow_pkg::flag_v];
        // with carry, zero only stays set across a chain of zero bytes
        if (with_carry) begin
            flags_out[flow_pkg::flag_z] = (res == 8'h00) & flags_in[flow_pkg::flag_z];
        end else begin
            flags_out[flow_pkg::flag_z] = (res == 8'h00);
        end
    end
endmodule : compare_flags

// File: logic/branch_compare_skip_unit.sv
// program-flow execution unit: returns, compares, skips and branches
`timescale 1ns/100ps
// Contract
// - equal registers skip next, no flag change
// - three one-cycle compares update six flags
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - io bit clear skips next instruction
// - io bit set skips next instruction
// - generic flag branches go to pc+k+1
// - equal/not-equal branch on zero flag
// - carry branches, one cycle or two
// - minus/plus branch on negative flag
// - signed branches on negative xor overflow
// - half-carry branches on half-carry flag
// - transfer-bit branches on T flag
module branch_compare_skip_unit (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // execution state
    output logic busy
);
    flow_pkg::instr_s instr;
    flow_pkg::operands_s opnd;
    logic [15:0] pc;
    logic [7:0] flags;
    logic [15:0] stack_addr;
    logic [2:0] cnt;
    flow_pkg::outcome_s pend;
    flow_pkg::outcome_s last;
    logic [15:0] retired;
    flow_pkg::outcome_s next_out;
    logic [7:0] cmp_flags;
    logic [7:0] cmp_sub;
    logic cmp_carry;
    logic wr_en;
    logic rd_go;
    logic start;
    logic mapped;

    // pc + 1 + signed word offset
    function automatic logic [15:0] rel_target(input logic [15:0] p, input logic [6:0] k);
        rel_target = p + 16'h0001 + {{9{k[6]}}, k};
    endfunction : rel_target

    // skipped instruction length decides the advance
    function automatic logic [15:0] skip_target(input logic [15:0] p, input logic two);
        skip_target = two ? p + 16'h0003 : p + 16'h0002;
    endfunction : skip_target

    function automatic logic addr_mapped(input logic [7:0] a);
        case (a)
            flow_pkg::ctrl_off, flow_pkg::instr_off, flow_pkg::opnd_off,
            flow_pkg::pc_off, flow_pkg::flags_off, flow_pkg::stack_off,
            flow_pkg::state_off, flow_pkg::retired_off: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    endfunction : addr_mapped

    assign mapped = addr_mapped(paddr);
    assign wr_en = psel & penable & pready & pwrite & mapped;
    assign rd_go = psel & penable & ~pready;
    assign start = wr_en & (paddr == flow_pkg::ctrl_off) & pwdata[0] & ~busy;

    always_comb begin
        case (instr.op)
            flow_pkg::compare_immediate: cmp_sub = opnd.opnd_b;
            default: cmp_sub = opnd.opnd_b;
        endcase
        cmp_carry = (instr.op == flow_pkg::compare_regs_with_carry);
    end

    compare_flags u_cmp (
        .minuend(opnd.opnd_a),
        .subtrahend(cmp_sub),
        .with_carry(cmp_carry),
        .flags_in(flags),
        .flags_out(cmp_flags)
    );

    // outcome of the instruction held in the instruction register
    always_comb begin
        logic skip;
        logic br;
        logic cond;
        skip = 1'b0;
        br = 1'b0;
        cond = 1'b0;
        next_out.pc = pc + 16'h0001;
        next_out.flags = flags;
        next_out.cycles = flow_pkg::cyc_plain;
        next_out.taken = 1'b0;
        next_out.bad_op = 1'b0;
        case (instr.op)
            flow_pkg::op_nop: begin
                next_out.pc = pc + 16'h0001;
            end
            flow_pkg::subroutine_return: begin
                next_out.pc = stack_addr;
                next_out.cycles = flow_pkg::cyc_return;
                next_out.taken = 1'b1;
            end
            flow_pkg::interrupt_return: begin
                next_out.pc = stack_addr;
                next_out.flags[flow_pkg::flag_i] = 1'b1;
                next_out.cycles = flow_pkg::cyc_return;
                next_out.taken = 1'b1;
            end
            flow_pkg::compare_skip_equal: skip = (opnd.opnd_a == opnd.opnd_b);
            flow_pkg::compare_regs,
            flow_pkg::compare_regs_with_carry,
            flow_pkg::compare_immediate: next_out.flags = cmp_flags;
            flow_pkg::skip_reg_bit_clear: skip = ~opnd.opnd_a[instr.bit_sel];
            flow_pkg::skip_reg_bit_set: skip = opnd.opnd_a[instr.bit_sel];
            flow_pkg::skip_io_bit_clear: skip = ~opnd.io_val[instr.bit_sel];
            flow_pkg::skip_io_bit_set: skip = opnd.io_val[instr.bit_sel];
            flow_pkg::branch_flag_set: begin
                br = 1'b1;
                cond = flags[instr.flag_sel];
            end
            flow_pkg::branch_flag_clear: begin
                br = 1'b1;
                cond = ~flags[instr.flag_sel];
            end
            flow_pkg::branch_equal: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_z];
            end
            flow_pkg::branch_not_equal: begin
                br = 1'b1;
                cond = ~flags[flow_pkg::flag_z];
            end
            flow_pkg::branch_carry_set, flow_pkg::branch_lower: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_c];
            end
            flow_pkg::branch_carry_clear, flow_pkg::branch_same_or_higher: begin
                br = 1'b1;
                cond = ~flags[flow_pkg::flag_c];
            end
            flow_pkg::branch_minus: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_n];
            end
            flow_pkg::branch_plus: begin
                br = 1'b1;
                cond = ~flags[flow_pkg::flag_n];
            end
            flow_pkg::branch_signed_ge: begin
                br = 1'b1;
                cond = ~(flags[flow_pkg::flag_n] ^ flags[flow_pkg::flag_v]);
            end
            flow_pkg::branch_signed_lt: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_n] ^ flags[flow_pkg::flag_v];
            end
            flow_pkg::branch_half_carry_set: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_h];
            end
            flow_pkg::branch_half_carry_clear: begin
                br = 1'b1;
                cond = ~flags[flow_pkg::flag_h];
            end
            flow_pkg::branch_transfer_bit_set: begin
                br = 1'b1;
                cond = flags[flow_pkg::flag_t];
            end
            flow_pkg::branch_transfer_bit_clear: begin
                br = 1'b1;
                cond = ~flags[flow_pkg::flag_t];
            end
            default: next_out.bad_op = 1'b1;
        endcase
        if (skip) begin
            next_out.pc = skip_target(pc, instr.two_word);
            next_out.cycles = instr.two_word ? flow_pkg::cyc_skip_long : flow_pkg::cyc_taken;
            next_out.taken = 1'b1;
        end
        if (br && cond) begin
            next_out.pc = rel_target(pc, instr.k);
            next_out.cycles = flow_pkg::cyc_taken;
            next_out.taken = 1'b1;
        end
    end

    // apb answer: one wait state, registered read data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (rd_go) begin
            pready <= 1'b1;
            pslverr <= ~mapped;
            prdata <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    flow_pkg::instr_off: begin
                        prdata[flow_pkg::op_pos +: 5] <= instr.op;
                        prdata[flow_pkg::bit_pos +: 3] <= instr.bit_sel;
                        prdata[flow_pkg::sel_pos +: 3] <= instr.flag_sel;
                        prdata[flow_pkg::k_pos +: 7] <= instr.k;
                        prdata[flow_pkg::two_word_pos] <= instr.two_word;
                    end
                    flow_pkg::opnd_off: prdata[23:0] <= opnd;
                    flow_pkg::pc_off: prdata[15:0] <= pc;
                    flow_pkg::flags_off: prdata[7:0] <= flags;
                    flow_pkg::stack_off: prdata[15:0] <= stack_addr;
                    flow_pkg::state_off: begin
                        prdata[flow_pkg::busy_pos] <= busy;
                        prdata[flow_pkg::taken_pos] <= last.taken;
                        prdata[flow_pkg::bad_op_pos] <= last.bad_op;
                        prdata[flow_pkg::cycles_pos +: 3] <= last.cycles;
                    end
                    flow_pkg::retired_off: prdata[15:0] <= retired;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // instruction and operand registers, locked while executing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= '0;
            opnd <= '0;
            stack_addr <= flow_pkg::stack_rst;
        end else if (wr_en && !busy) begin
            case (paddr)
                flow_pkg::instr_off: begin
                    instr.op <= flow_pkg::op_e'(pwdata[flow_pkg::op_pos +: 5]);
                    instr.bit_sel <= pwdata[flow_pkg::bit_pos +: 3];
                    instr.flag_sel <= pwdata[flow_pkg::sel_pos +: 3];
                    instr.k <= pwdata[flow_pkg::k_pos +: 7];
                    instr.two_word <= pwdata[flow_pkg::two_word_pos];
                end
                flow_pkg::opnd_off: opnd <= pwdata[23:0];
                flow_pkg::stack_off: stack_addr <= pwdata[15:0];
                default: stack_addr <= stack_addr;
            endcase
        end
    end

    // execution sequencer: result commits on the last cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            cnt <= 3'h0;
            pend <= '0;
            last <= '0;
            retired <= 16'h0000;
        end else if (start) begin
            busy <= 1'b1;
            cnt <= next_out.cycles;
            pend <= next_out;
        end else if (busy) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1) begin
                busy <= 1'b0;
                last <= pend;
                retired <= retired + 16'h0001;
            end
        end
    end

    // program counter and flags: software writes when idle, commit otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc <= flow_pkg::pc_rst;
            flags <= flow_pkg::flags_rst;
        end else if (busy && cnt == 3'h1) begin
            pc <= pend.pc;
            flags <= pend.flags;
        end else if (wr_en && !busy) begin
            if (paddr == flow_pkg::pc_off) begin
                pc <= pwdata[15:0];
            end
            if (paddr == flow_pkg::flags_off) begin
                flags <= pwdata[7:0];
            end
        end
    end
endmodule : branch_compare_skip_unit

// File: tb/branch_compare_skip_unit_chk.sv
// concurrent checks on the apb and busy ports of the program-flow unit
`timescale 1ns/100ps
module branch_compare_skip_unit_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // execution state
    input wire logic busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic done;
    logic start;
    assign done = psel && penable && pready;
    assign start = done && pwrite && paddr == flow_pkg::ctrl_off && pwdata[0];
    ready_one_wait_a: assert property (psel && !penable |=> penable && !pready ##1 pready)
        else $error("pready missing after one wait state");
    ready_in_access_a: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_unmapped_a: assert property (done && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h1c))
        else $error("pslverr does not match address map");
    err_read_zero_a: assert property (done && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    start_sets_busy_a: assert property (start && !busy |=> busy)
        else $error("start did not raise busy");
    busy_bounded_a: assert property ($rose(busy) |-> ##[1:4] !busy)
        else $error("execution longer than four cycles");
    busy_cause_a: assert property ($rose(busy) |-> $past(start))
        else $error("busy rose without a start");
    cover property (done && pslverr);
    cover property ($rose(busy) ##1 !busy);
    cover property ($rose(busy) ##3 busy ##1 !busy);
endmodule : branch_compare_skip_unit_chk
bind branch_compare_skip_unit branch_compare_skip_unit_chk u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

// File: tb/apb_master.sv
// apb master model standing in for the software side of the unit
`timescale 1ns/100ps
module apb_master (
    // clock
    input wire logic pclk,
    // request
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0,
    // answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rv, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_master

// File: tb/branch_compare_skip_unit_tb.sv
// self-checking bench for the program-flow unit
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module branch_compare_skip_unit_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, busy, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, d;
    int fails = 0;
    int n_tests = 0;
    int retired = 0;
    logic [7:0] fv [4] = '{8'h00, 8'hff, 8'h0a, 8'h35};
    logic [4:0] sk [5] = '{5'h03, 5'h07, 5'h08, 5'h09, 5'h0a};
    logic [31:0] cv [6] = '{32'h04100100, 32'h04800100, 32'h05050401, 32'h05050403,
        32'h060505c0, 32'h040102ff};
    initial begin
        forever #25 pclk = ~pclk;
    end
    apb_master u_apb_master (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    branch_compare_skip_unit u_branch_compare_skip_unit (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        u_apb_master.xfer(1'b1, a, v, x, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_apb_master.xfer(1'b0, a, 32'h0, d, e);
    endtask : rd
    function automatic logic [31:0] mk(input logic [4:0] op, input logic [2:0] b,
        input logic [2:0] s, input logic [6:0] k, input logic tw);
        return {7'h0, tw, 1'b0, k, 1'b0, s, 1'b0, b, 3'h0, op};
    endfunction : mk
    function automatic logic taken(input logic [4:0] op, input logic [7:0] f, input logic [2:0] s);
        case (op)
            5'h0b: return f[s];
            5'h0c: return !f[s];
            5'h0d: return f[1];
            5'h0e: return !f[1];
            5'h0f, 5'h12: return f[0];
            5'h10, 5'h11: return !f[0];
            5'h13: return f[2];
            5'h14: return !f[2];
            5'h15: return !(f[2] ^ f[3]);
            5'h16: return f[2] ^ f[3];
            5'h17: return f[5];
            5'h18: return !f[5];
            5'h19: return f[6];
            default: return !f[6];
        endcase
    endfunction : taken
    function automatic logic [7:0] cmpf(input logic [4:0] op, input logic [7:0] a, b, f);
        logic c;
        logic [8:0] r;
        logic [7:0] o;
        c = (op == 5'h05) & f[0];
        r = {1'b0, a} - {1'b0, b} - {8'h00, c};
        o = f;
        o[0] = r[8];
        o[1] = (r[7:0] == 8'h00) & ((op != 5'h05) | f[1]);
        o[2] = r[7];
        o[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
        o[4] = o[2] ^ o[3];
        o[5] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
        return o;
    endfunction : cmpf
    task automatic run(input logic [31:0] ins, input logic [23:0] opn, input logic [15:0] p0,
        input logic [7:0] f0, input logic [15:0] ep, input logic [7:0] ef, input logic [2:0] ec);
        int n;
        wr(flow_pkg::instr_off, ins);
        wr(flow_pkg::opnd_off, {8'h00, opn});
        wr(flow_pkg::pc_off, {16'h0000, p0});
        wr(flow_pkg::flags_off, {24'h0, f0});
        wr(flow_pkg::ctrl_off, 32'h1);
        retired++;
        n = 0;
        @(posedge pclk);
        while (busy !== 1'b0 && n < 10) begin
            @(posedge pclk);
            n++;
        end
        `CHK(busy, 1'b0)
        rd(flow_pkg::pc_off);
        `CHK(d[15:0], ep)
        rd(flow_pkg::flags_off);
        `CHK(d[7:0], ef)
        rd(flow_pkg::state_off);
        `CHK(d[6:4], ec)
        `CHK(d[1], ec != 3'h1)
    endtask : run
    task automatic final_report();
        $display("checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    initial begin
        int i;
        int j;
        logic [4:0] op;
        logic [6:0] k;
        logic [15:0] ep;
        logic [7:0] v;
        logic [2:0] c;
        logic t;
        logic [23:0] opn;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 32; i += 4) begin
            rd(8'(i));
            `CHK(d, 32'h0)
        end
        $display("reset test done");
        for (op = 5'h0b; op <= 5'h1a; op++) begin
            for (i = 0; i < 4; i++) begin
                k = i[0] ? 7'h3f : 7'h7e;
                t = taken(op, fv[i], op[2:0]);
                ep = t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101;
                run(mk(op, 3'h0, op[2:0], k, 1'b0), 24'h0, 16'h0100, fv[i], ep, fv[i],
                    t ? 3'h2 : 3'h1);
            end
        end
        $display("branch test done");
        for (j = 0; j < 5; j++) begin
            for (i = 0; i < 4; i++) begin
                op = sk[j];
                v = (i[0] == (op == 5'h08 || op == 5'h0a)) ? 8'ha5 : 8'h5a;
                c = i[0] ? (i[1] ? 3'h3 : 3'h2) : 3'h1;
                opn = (op == 5'h03) ? {8'h00, i[0] ? 8'h77 : 8'h78, 8'h77} :
                    (op < 5'h09) ? {~v, 8'h00, v} : {v, 8'h00, ~v};
                run(mk(op, 3'h2, 3'h0, 7'h0, i[1]), opn, 16'h0200, 8'hc3, 16'h0200 + c,
                    8'hc3, c);
            end
        end
        $display("skip test done");
        for (i = 0; i < 6; i++) begin
            run(mk(cv[i][28:24], 3'h0, 3'h0, 7'h0, 1'b0), {8'h00, cv[i][15:8], cv[i][23:16]},
                16'h0300, cv[i][7:0], 16'h0301, cmpf(cv[i][28:24], cv[i][23:16], cv[i][15:8],
                cv[i][7:0]), 3'h1);
        end
        $display("compare test done");
        wr(flow_pkg::stack_off, 32'h1234);
        run(mk(5'h01, 3'h0, 3'h0, 7'h0, 1'b0), 24'h0, 16'h0005, 8'h7f, 16'h1234, 8'h7f, 3'h4);
        run(mk(5'h02, 3'h0, 3'h0, 7'h0, 1'b0), 24'h0, 16'h0005, 8'h05, 16'h1234, 8'h85, 3'h4);
        wr(flow_pkg::ctrl_off, 32'h1);
        wr(flow_pkg::pc_off, 32'hbeef);
        retired++;
        repeat (4) @(posedge pclk);
        rd(flow_pkg::pc_off);
        `CHK(d[15:0], 16'h1234)
        $display("return test done");
        run(mk(5'h1f, 3'h0, 3'h0, 7'h0, 1'b0), 24'h0, 16'h0010, 8'h00, 16'h0011, 8'h00, 3'h1);
        rd(flow_pkg::state_off);
        `CHK(d[2], 1'b1)
        rd(8'h40);
        `CHK(e, 1'b1)
        `CHK(d, 32'h0)
        wr(8'h80, 32'h1);
        `CHK(e, 1'b1)
        wr(flow_pkg::retired_off, 32'hffff);
        rd(flow_pkg::retired_off);
        `CHK(d, 32'(retired))
        $display("access test done");
        final_report();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        final_report();
    end
endmodule : branch_compare_skip_unit_tb
